//--- hdl/clock_switch_control.sv
// Purpose: Clock switch control and status registers with switch sequencing
// Assumes: APB slave, zero wait states; analog ready levels are asynchronous
// Notes:   Request and current fields load from the reset source straps after reset release
//
// Behaviour
// - Source code: 111 ext, 110 HF, 101 LF, 100 sec, 010 ext+PLL, 001 HF+PLL.
// - Divider code 0000..1001 divides by 1..512; 1010..1111 reserved.
// - A write with a reserved source code is ignored entirely.
// - Switch permit strap low makes the request register read-only.
// - Requested source resets from the reset source straps.
// - Requested divider resets to 0010 for source 110, else 0000.
// - Current fields are read-only and reset to the requested values.
// - Hold set and new source ready: wait and pulse switch interrupt.
// - Hold clear: switch as soon as new source ready rises.
// - Switch done reads 1 when request equals current, else 0.
// - New source ready reads 1 only mid-switch with requested oscillator ready.
// - With hold clear, new source ready lasts a single clock cycle.
// - Secondary power select, bit 6 of control register, resets to 0.
// - Hold bit 7 R/W hardware-cleared; done bit 4, new-ready bit 3 read-only.
// - Oscillator ready flags in bits 7..2, read-only.
// - PLL ready bit 0: enabled, input source ready and locked.
// - Six manual enable bits 7..2, read/write, reset to 0.
// - Current fields change only at the switch, which sets done and clears new-ready.
// - Manual enable forces oscillator on; otherwise on peripheral request or behind the current or requested source (current PLL input only if request has no PLL).
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module clock_switch_control
  import clock_switch_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Configuration straps
  input  wire logic [2:0]        reset_source_config,
  input  wire logic              switch_permit_config,
  // Oscillator sources and PLL
  input  wire logic [NUM_OSC-1:0] osc_ready_raw,
  input  wire logic              pll_lock_raw,
  input  wire logic [NUM_OSC-1:0] periph_request,
  output logic      [NUM_OSC-1:0] osc_enable,
  output logic                   pll_enable,
  output logic                   secondary_power_select,
  // Clock selection and events
  output logic      [2:0]        current_source,
  output logic      [3:0]        current_divider,
  output logic                   switch_irq
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic is_reserved_src(input logic [2:0] src);
    is_reserved_src = (src == SRC_RSVD_3) || (src == SRC_RSVD_0);
  endfunction

  function automatic logic is_pll_src(input logic [2:0] src);
    is_pll_src = (src == SRC_EXT_PLL) || (src == SRC_HF_PLL);
  endfunction

  // Ready of the oscillator behind a source code
  function automatic logic src_osc_ready(input logic [2:0] src, input logic [NUM_OSC-1:0] rdy,
                                         input logic pll_rdy);
    case (src)
      SRC_EXT:     src_osc_ready = rdy[OSC_EXT];
      SRC_HF:      src_osc_ready = rdy[OSC_HF];
      SRC_LF:      src_osc_ready = rdy[OSC_LF];
      SRC_SEC:     src_osc_ready = rdy[OSC_SEC];
      SRC_EXT_PLL: src_osc_ready = pll_rdy;
      SRC_HF_PLL:  src_osc_ready = pll_rdy;
      default:     src_osc_ready = 1'b0;
    endcase
  endfunction

  // Reset divider follows the source
  function automatic logic [3:0] reset_divider(input logic [2:0] src);
    reset_divider = (src == SRC_HF) ? DIV_BY_4 : DIV_BY_1;
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // ************************************************************
  // Synchronised source status
  // ************************************************************
  logic [NUM_OSC-1:0] osc_ready;
  logic               pll_lock;

  ready_sync #(
    .WIDTH (NUM_OSC + 1)
  ) u_ready_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({osc_ready_raw, pll_lock_raw}),
    .sync_out ({osc_ready, pll_lock})
  );

  // ************************************************************
  // State
  // ************************************************************
  logic [2:0]          req_source_q,  req_source_d;
  logic [3:0]          req_divider_q, req_divider_d;
  logic [2:0]          cur_source_q,  cur_source_d;
  logic [3:0]          cur_divider_q, cur_divider_d;
  logic                hold_q,        hold_d;
  logic                sec_power_q,   sec_power_d;
  logic [NUM_OSC-1:0]  manual_en_q,   manual_en_d;
  logic                loaded_q,      loaded_d;
  logic                permit_q,      permit_d;
  switch_state_t       state_q,       state_d;
  logic                new_ready_prev_q, new_ready_prev_d;
  logic                irq_q,         irq_d;
  logic [31:0]         rdata_q,       rdata_d;
  logic                err_q,         err_d;

  // ************************************************************
  // Status decode
  // ************************************************************
  logic       pll_input_ready;
  logic       pll_locked_ready;
  logic       req_osc_ready;
  logic       in_progress;
  logic       switch_done;
  logic       new_source_ready;
  logic       do_switch;
  logic [2:0] pll_src;

  always_comb begin
    pll_src          = is_pll_src(req_source_q) ? req_source_q : cur_source_q;
    pll_enable       = is_pll_src(req_source_q) || is_pll_src(cur_source_q);
    pll_input_ready  = (pll_src == SRC_EXT_PLL) ? osc_ready[OSC_EXT] : osc_ready[OSC_HF];
    pll_locked_ready = pll_enable && pll_input_ready && pll_lock;
    req_osc_ready    = src_osc_ready(req_source_q, osc_ready, pll_locked_ready);
    in_progress      = loaded_q && ((req_source_q != cur_source_q) || (req_divider_q != cur_divider_q));
    switch_done      = !in_progress;
    new_source_ready = in_progress && req_osc_ready;
    do_switch        = new_source_ready && !hold_q;
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  logic        setup_ph;
  logic        wr_access;
  logic        hit_req, hit_cur, hit_ctl, hit_rdy, hit_men;
  logic        mapped;
  logic [7:0]  wbyte;
  logic        wr_req, wr_ctl, wr_men;

  always_comb begin
    hit_req = 1'b0;
    hit_cur = 1'b0;
    hit_ctl = 1'b0;
    hit_rdy = 1'b0;
    hit_men = 1'b0;
    if (paddr == byte_addr(IDX_REQUEST)) begin
      hit_req = 1'b1;
    end else if (paddr == byte_addr(IDX_CURRENT)) begin
      hit_cur = 1'b1;
    end else if (paddr == byte_addr(IDX_CONTROL)) begin
      hit_ctl = 1'b1;
    end else if (paddr == byte_addr(IDX_READY)) begin
      hit_rdy = 1'b1;
    end else if (paddr == byte_addr(IDX_MANUAL_EN)) begin
      hit_men = 1'b1;
    end
    mapped    = hit_req || hit_cur || hit_ctl || hit_rdy || hit_men;
    setup_ph  = psel && !penable;
    wr_access = psel && penable && pwrite && pstrb[0];
    wbyte     = pwdata[7:0];
    wr_req    = wr_access && hit_req && loaded_q && permit_q
                && !is_reserved_src(wbyte[SRC_LSB +: 3]);
    wr_ctl    = wr_access && hit_ctl;
    wr_men    = wr_access && hit_men;
  end

  // ************************************************************
  // Register and switch next state
  // ************************************************************
  always_comb begin
    req_source_d     = req_source_q;
    req_divider_d    = req_divider_q;
    cur_source_d     = cur_source_q;
    cur_divider_d    = cur_divider_q;
    hold_d           = hold_q;
    sec_power_d      = sec_power_q;
    manual_en_d      = manual_en_q;
    loaded_d         = 1'b1;
    permit_d         = permit_q;
    state_d          = state_q;
    new_ready_prev_d = new_source_ready;
    irq_d            = new_source_ready && !new_ready_prev_q;
    if (!loaded_q) begin
      req_source_d  = reset_source_config;
      req_divider_d = reset_divider(reset_source_config);
      cur_source_d  = reset_source_config;
      cur_divider_d = reset_divider(reset_source_config);
      permit_d      = switch_permit_config;
      irq_d         = 1'b0;
    end else begin
      if (wr_req) begin
        req_source_d  = wbyte[SRC_LSB +: 3];
        req_divider_d = wbyte[DIV_LSB +: 4];
      end
      if (do_switch) begin
        cur_source_d  = req_source_q;
        cur_divider_d = req_divider_q;
      end
      if (wr_ctl) begin
        sec_power_d = wbyte[SEC_POWER_BIT];
        hold_d      = wbyte[HOLD_BIT];
      end else if (wr_req && (wbyte[SRC_LSB +: 3] == cur_source_q)
                   && (wbyte[DIV_LSB +: 4] == cur_divider_q)) begin
        hold_d = 1'b0;
      end
      if (wr_men) begin
        manual_en_d = wbyte[MANUAL_EN_LSB +: NUM_OSC];
      end
    end
    case (state_q)
      SW_IDLE: begin
        if (in_progress) begin
          state_d = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (!in_progress || do_switch) begin
          state_d = SW_IDLE;
        end else if (new_source_ready && hold_q) begin
          state_d = SW_HOLD;
        end
      end
      SW_HOLD: begin
        if (!in_progress || do_switch) begin
          state_d = SW_IDLE;
        end else if (!new_source_ready) begin
          state_d = SW_WAIT;
        end
      end
      default: begin
        state_d = SW_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup_ph) begin
      rdata_d = RST_RDATA;
      err_d   = !mapped;
      if (hit_req) begin
        rdata_d[SRC_LSB +: 3] = req_source_q;
        rdata_d[DIV_LSB +: 4] = req_divider_q;
      end else if (hit_cur) begin
        rdata_d[SRC_LSB +: 3] = cur_source_q;
        rdata_d[DIV_LSB +: 4] = cur_divider_q;
      end else if (hit_ctl) begin
        rdata_d[HOLD_BIT]      = hold_q;
        rdata_d[SEC_POWER_BIT] = sec_power_q;
        rdata_d[DONE_BIT]      = switch_done;
        rdata_d[NEW_READY_BIT] = new_source_ready;
      end else if (hit_rdy) begin
        rdata_d[OSC_READY_LSB +: NUM_OSC] = osc_ready;
        rdata_d[PLL_READY_BIT]            = pll_locked_ready;
      end else if (hit_men) begin
        rdata_d[MANUAL_EN_LSB +: NUM_OSC] = manual_en_q;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_source_q     <= RST_SOURCE;
      req_divider_q    <= RST_DIVIDER;
      cur_source_q     <= RST_SOURCE;
      cur_divider_q    <= RST_DIVIDER;
      hold_q           <= RST_HOLD;
      sec_power_q      <= RST_SEC_POWER;
      manual_en_q      <= RST_MANUAL_EN;
      loaded_q         <= 1'b0;
      permit_q         <= 1'b0;
      state_q          <= SW_IDLE;
      new_ready_prev_q <= 1'b0;
      irq_q            <= 1'b0;
      rdata_q          <= RST_RDATA;
      err_q            <= 1'b0;
    end else begin
      req_source_q     <= req_source_d;
      req_divider_q    <= req_divider_d;
      cur_source_q     <= cur_source_d;
      cur_divider_q    <= cur_divider_d;
      hold_q           <= hold_d;
      sec_power_q      <= sec_power_d;
      manual_en_q      <= manual_en_d;
      loaded_q         <= loaded_d;
      permit_q         <= permit_d;
      state_q          <= state_d;
      new_ready_prev_q <= new_ready_prev_d;
      irq_q            <= irq_d;
      rdata_q          <= rdata_d;
      err_q            <= err_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic [NUM_OSC-1:0] src_need;

  // Oscillators behind the active or requested source stay powered, the active PLL input only when the requested source uses no PLL
  always_comb begin
    src_need          = '0;
    src_need[OSC_EXT] = (cur_source_q == SRC_EXT) || (req_source_q == SRC_EXT)
                        || (pll_enable && (pll_src == SRC_EXT_PLL));
    src_need[OSC_HF]  = (cur_source_q == SRC_HF) || (req_source_q == SRC_HF)
                        || (pll_enable && (pll_src == SRC_HF_PLL));
    src_need[OSC_LF]  = (cur_source_q == SRC_LF) || (req_source_q == SRC_LF);
    src_need[OSC_SEC] = (cur_source_q == SRC_SEC) || (req_source_q == SRC_SEC);
  end

  assign osc_enable             = manual_en_q | periph_request | src_need;
  assign secondary_power_select = sec_power_q;
  assign current_source         = cur_source_q;
  assign current_divider        = cur_divider_q;
  assign switch_irq             = irq_q;
  assign prdata                 = rdata_q;
  assign pready                 = 1'b1;
  assign pslverr                = err_q && psel && penable;

endmodule

//--- hdl/clock_switch_pkg.sv
// Purpose: Shared constants and types of the clock switch control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register index constants are the printed offsets; byte address is four times the index
package clock_switch_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] IDX_REQUEST   = 12'h088D;
  localparam logic [11:0] IDX_CURRENT   = 12'h088E;
  localparam logic [11:0] IDX_CONTROL   = 12'h088F;
  localparam logic [11:0] IDX_READY     = 12'h0890;
  localparam logic [11:0] IDX_MANUAL_EN = 12'h0891;
  localparam int          ADDR_W        = 16;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SRC_LSB         = 4;
  localparam int DIV_LSB         = 0;
  localparam int HOLD_BIT        = 7;
  localparam int SEC_POWER_BIT   = 6;
  localparam int DONE_BIT        = 4;
  localparam int NEW_READY_BIT   = 3;
  localparam int OSC_READY_LSB   = 2;
  localparam int PLL_READY_BIT   = 0;
  localparam int MANUAL_EN_LSB   = 2;
  localparam int NUM_OSC         = 6;

  // Oscillator vector order, high to low
  localparam int OSC_EXT  = 5;
  localparam int OSC_HF   = 4;
  localparam int OSC_MF   = 3;
  localparam int OSC_LF   = 2;
  localparam int OSC_SEC  = 1;
  localparam int OSC_CONV = 0;

  // ************************************************************
  // Source and divider encodings
  // ************************************************************
  typedef enum logic [2:0] {
    SRC_EXT     = 3'h7,
    SRC_HF      = 3'h6,
    SRC_LF      = 3'h5,
    SRC_SEC     = 3'h4,
    SRC_RSVD_3  = 3'h3,
    SRC_EXT_PLL = 3'h2,
    SRC_HF_PLL  = 3'h1,
    SRC_RSVD_0  = 3'h0
  } source_t;

  localparam logic [3:0] DIV_BY_1   = 4'h0;
  localparam logic [3:0] DIV_BY_4   = 4'h2;
  localparam logic [3:0] DIV_BY_512 = 4'h9;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2:0] RST_SOURCE    = 3'h6;
  localparam logic [3:0] RST_DIVIDER   = 4'h2;
  localparam logic       RST_HOLD      = 1'b0;
  localparam logic       RST_SEC_POWER = 1'b0;
  localparam logic [5:0] RST_MANUAL_EN = 6'h00;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

  // Switch sequencer states, Gray coded
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_HOLD = 2'b11
  } switch_state_t;

endpackage

//--- hdl/ready_sync.sv
// Purpose: Two-flop synchroniser for oscillator ready and lock levels
// Assumes: Inputs are quasi-static levels from analog sources
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module ready_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

//--- verification/clock_switch_asserts.sv
// Purpose: Port-level checks for clock_switch_control
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the design
`timescale 1ns/1ns
module clock_switch_asserts
  import clock_switch_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Sources and selection
  input wire logic [NUM_OSC-1:0] periph_request,
  input wire logic [NUM_OSC-1:0] osc_enable,
  input wire logic               pll_enable,
  input wire logic               secondary_power_select,
  input wire logic [2:0]         current_source,
  input wire logic               switch_irq
);
  localparam logic [15:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[15:2] >= {2'b00, IDX_REQUEST})
                  && (paddr[15:2] <= {2'b00, IDX_MANUAL_EN});

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pready_on: assert property (pready)
    else $error("pready low");
  chk_err_unmap: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (!(acc && !mapped) |-> !pslverr)
    else $error("error on mapped access");
  chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_power_write: assert property (acc && pwrite && pstrb[0] && paddr == A_CTL
    |=> secondary_power_select == $past(pwdata[SEC_POWER_BIT]))
    else $error("power select not written");
  chk_irq_pulse: assert property (switch_irq |=> !switch_irq)
    else $error("switch event longer than one cycle");
  chk_src_legal: assert property (current_source != SRC_RSVD_3 && current_source != SRC_RSVD_0)
    else $error("current source reserved");
  chk_pll_on: assert property (current_source inside {SRC_EXT_PLL, SRC_HF_PLL} |-> pll_enable)
    else $error("PLL off while selected");
  chk_periph_on: assert property ((periph_request & ~osc_enable) == 6'h00)
    else $error("requested oscillator not enabled");
endmodule

bind clock_switch_control clock_switch_asserts u_clock_switch_asserts (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_request(periph_request), .osc_enable(osc_enable), .pll_enable(pll_enable),
  .secondary_power_select(secondary_power_select), .current_source(current_source),
  .switch_irq(switch_irq)
);

//--- verification/tb.sv
// Purpose: Self-checking bench for clock_switch_control
// Assumes: Zero-wait APB slave, straps sampled after reset release
// Notes:   Every wait is bounded and ends the run when it expires
`timescale 1ns/1ns
module tb;
  import clock_switch_pkg::*;
  localparam logic [15:0] A_REQ = {2'b00, IDX_REQUEST, 2'b00};
  localparam logic [15:0] A_CUR = {2'b00, IDX_CURRENT, 2'b00};
  localparam logic [15:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [15:0] A_RDY = {2'b00, IDX_READY, 2'b00};
  localparam logic [15:0] A_MAN = {2'b00, IDX_MANUAL_EN, 2'b00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  reset_source_config = 3'h6;
  logic        switch_permit_config = 1'b1;
  logic [5:0]  osc_ready_raw = 6'h00;
  logic        pll_lock_raw = 1'b1;
  logic [5:0]  periph_request = 6'h00;
  logic [5:0]  osc_enable;
  logic        pll_enable;
  logic        secondary_power_select;
  logic [2:0]  current_source;
  logic [3:0]  current_divider;
  logic        switch_irq;
  logic [31:0] rd;
  logic        rerr;
  int          errors = 0;
  int          checked = 0;

  always #4 clk = ~clk;

  clock_switch_control u_clock_switch_control (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_source_config(reset_source_config), .switch_permit_config(switch_permit_config),
    .osc_ready_raw(osc_ready_raw), .pll_lock_raw(pll_lock_raw), .periph_request(periph_request),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .secondary_power_select(secondary_power_select),
    .current_source(current_source), .current_divider(current_divider), .switch_irq(switch_irq)
  );

  // ************************************************************
  // Common tasks
  // ************************************************************
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic fail_hang;
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) fail_hang();
      @(posedge clk);
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    cmp(rd[7:0], exp);
  endtask

  // Waits for the switch event or for a given current source
  task automatic wait_on(input bit irq, input logic [2:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 40) fail_hang();
    end while (irq ? (switch_irq !== 1'b1) : (current_source !== s));
  endtask

  task automatic do_reset(input logic [2:0] s, input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    reset_source_config <= s;
    switch_permit_config <= p;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic s_reset;
    rd_chk(A_REQ, 8'h62);
    rd_chk(A_CUR, 8'h62);
    rd_chk(A_CTL, 8'h10);
    rd_chk(A_RDY, 8'h00);
    rd_chk(A_MAN, 8'h00);
    apb(1'b1, A_REQ, 8'h35);
    rd_chk(A_REQ, 8'h62);
    apb(1'b1, A_REQ, 8'h05);
    rd_chk(A_REQ, 8'h62);
  endtask

  task automatic s_no_hold;
    apb(1'b1, A_REQ, 8'h59);
    rd_chk(A_CTL, 8'h00);
    rd_chk(A_CUR, 8'h62);
    osc_ready_raw[OSC_LF] <= 1'b1;
    wait_on(1'b0, SRC_LF);
    cmp({4'h0, current_divider}, 8'h09);
    cmp({7'h00, switch_irq}, 8'h01);
    rd_chk(A_CTL, 8'h10);
  endtask

  task automatic s_hold;
    apb(1'b1, A_CTL, 8'h80);
    apb(1'b1, A_REQ, 8'h60);
    rd_chk(A_CTL, 8'h80);
    osc_ready_raw[OSC_HF] <= 1'b1;
    wait_on(1'b1, SRC_HF);
    rd_chk(A_CTL, 8'h88);
    rd_chk(A_CUR, 8'h59);
    apb(1'b1, A_CTL, 8'h40);
    wait_on(1'b0, SRC_HF);
    cmp({7'h00, secondary_power_select}, 8'h01);
    rd_chk(A_CTL, 8'h50);
    apb(1'b1, A_CTL, 8'hC0);
    apb(1'b1, A_REQ, 8'h59);
    apb(1'b1, A_REQ, 8'h60);
    rd_chk(A_CTL, 8'h50);
    rd_chk(A_CUR, 8'h60);
  endtask

  task automatic s_codes;
    logic [2:0] codes [6] = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h5, 3'h6};
    osc_ready_raw <= 6'h3F;
    foreach (codes[k]) begin
      apb(1'b1, A_REQ, {1'b0, codes[k], 4'(k + 4)});
      wait_on(1'b0, codes[k]);
      cmp({4'h0, current_divider}, 8'(k + 4));
      if (codes[k] == SRC_HF_PLL) rd_chk(A_RDY, 8'hFD);
    end
    rd_chk(A_RDY, 8'hFC);
  endtask

  task automatic s_map;
    periph_request <= 6'h15;
    apb(1'b1, A_MAN, 8'hFF);
    rd_chk(A_MAN, 8'hFC);
    cmp({2'b00, osc_enable}, 8'h3F);
    apb(1'b1, A_MAN, 8'h00);
    apb(1'b1, A_CUR, 8'h00);
    cmp({7'h00, rerr}, 8'h00);
    cmp({2'b00, osc_enable}, 8'h15);
    rd_chk(A_CUR, 8'h69);
    rd_chk(16'h2248, 8'h00);
    cmp({7'h00, rerr}, 8'h01);
  endtask

  task automatic s_permit;
    do_reset(3'h7, 1'b0);
    rd_chk(A_REQ, 8'h70);
    apb(1'b1, A_REQ, 8'h60);
    rd_chk(A_REQ, 8'h70);
    rd_chk(A_CUR, 8'h70);
  endtask

  initial begin
    do_reset(3'h6, 1'b1);
    s_reset();
    s_no_hold();
    s_hold();
    s_codes();
    s_map();
    s_permit();
    report_and_stop();
  end
endmodule
